// *** design/input_terminal_pkg.sv ***
// Constants, register map and types for the input-terminal block
package input_terminal_pkg;
  localparam longint CLK_HZ = 64'd250_000_000;
  localparam longint RESET_MIN_MS = 64'd12;
  localparam longint ALARM_CLEAR_MAX_MS = 64'd30;
  localparam longint OFF_DELAY_EXTRA_MS = 64'd1000;
  // Least times round up to whole cycles
  localparam longint RESET_MIN_CYCLES = (RESET_MIN_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam longint OFF_DELAY_CYCLES = (OFF_DELAY_EXTRA_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam int CNT_W = 28;
  localparam logic [3:0] AT_DEBOUNCE_CYCLES = 4'h8;
  localparam int NUM_TERMINALS = 5;
  localparam int NUM_LOGIC_OUT = 3;

  // Register byte offsets
  localparam logic [7:0] FUNC_MAP_OFFSET = 8'h00;
  localparam logic [7:0] POLARITY_OFFSET = 8'h04;
  localparam logic [7:0] FREQ_CFG_OFFSET = 8'h08;
  localparam logic [7:0] OFF_DELAY_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // Field layout
  localparam int FUNC_CODE_W = 5;
  localparam int FREQ_SRC_LSB = 0;
  localparam int ANALOG_SEL_LSB = 8;
  localparam int DELAY_A_LSB = 0;
  localparam int DELAY_B_LSB = 8;
  localparam int DELAY_C_LSB = 16;

  // Reset values
  localparam logic [24:0] FUNC_MAP_RESET = 25'h000_0000;
  localparam logic [4:0] POLARITY_RESET = 5'h00;
  localparam logic [7:0] FREQ_SRC_RESET = 8'h01;
  localparam logic [7:0] ANALOG_SEL_RESET = 8'h00;

  // Input function codes
  localparam logic [4:0] FUNC_USP = 5'h0D;
  localparam logic [4:0] FUNC_CURRENT_SELECT = 5'h10;
  localparam logic [4:0] FUNC_RESET = 5'h12;

  // Setting codes
  localparam logic [7:0] FREQ_SRC_ANALOG = 8'h01;
  localparam logic [7:0] ASEL_POT_OR_VOLTAGE = 8'h02;
  localparam logic [7:0] ASEL_POT_OR_CURRENT = 8'h03;
  localparam logic [7:0] ASEL_VOLTAGE_ONLY = 8'h04;
  localparam logic [7:0] ASEL_CURRENT_ONLY = 8'h05;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_VOLTAGE,
    SRC_CURRENT,
    SRC_KEYPAD_POT
  } analog_source_e;
endpackage : input_terminal_pkg

// *** design/input_terminal.sv ***
// Analog source selection and reset-input handling behind an AHB-Lite register port
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module input_terminal
  import input_terminal_pkg::*;
#(
  parameter logic [CNT_W-1:0] RESET_MIN = CNT_W'(RESET_MIN_CYCLES),
  parameter logic [CNT_W-1:0] OFF_DELAY = CNT_W'(OFF_DELAY_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NUM_TERMINALS-1:0] terminal_in,
  input wire logic run_cmd,
  input wire logic trip_event,
  input wire logic [NUM_LOGIC_OUT-1:0] logic_out_req,
  output logic [1:0] analog_source,
  output logic motor_drive,
  output logic [NUM_LOGIC_OUT-1:0] logic_out,
  output logic alarm_out
);

  typedef enum logic [1:0] {
    ST_POWER_UP,
    ST_NORMAL,
    ST_RESET_HOLD
  } phase_e;

  // Level of an input function: OR over all terminals carrying its code, zero if unmapped
  function automatic logic func_level(input logic [24:0] map, input logic [4:0] lvl, input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMINALS; i++) begin
      if (map[i*FUNC_CODE_W +: FUNC_CODE_W] == code) begin
        hit = hit | lvl[i];
      end
    end
    return hit;
  endfunction : func_level

  // Registers
  logic [24:0] func_map;
  logic [4:0] polarity;
  logic [7:0] freq_source_setting;
  logic [7:0] analog_select_setting;
  logic [7:0] output_off_delay_a;
  logic [7:0] output_off_delay_b;
  logic [7:0] output_off_delay_c;
  logic [24:0] next_func_map;
  logic [4:0] next_polarity;
  logic [7:0] next_freq_source_setting;
  logic [7:0] next_analog_select_setting;
  logic [7:0] next_output_off_delay_a;
  logic [7:0] next_output_off_delay_b;
  logic [7:0] next_output_off_delay_c;

  // Bus state
  logic wr_pending;
  logic [7:0] wr_addr;
  logic [31:0] next_hrdata;
  logic next_wr_pending;
  logic [7:0] next_wr_addr;

  // Control state
  phase_e phase;
  phase_e next_phase;
  logic [CNT_W-1:0] rs_cnt;
  logic [CNT_W-1:0] next_rs_cnt;
  logic [CNT_W-1:0] off_cnt;
  logic [CNT_W-1:0] next_off_cnt;
  logic rs_prev;
  logic trip;
  logic next_trip;
  logic at_filt;
  logic next_at_filt;
  logic [3:0] at_cnt;
  logic [3:0] next_at_cnt;
  logic [1:0] next_analog_source;
  logic next_motor_drive;
  logic [NUM_LOGIC_OUT-1:0] next_logic_out;

  logic addr_phase;
  logic [4:0] term_lvl;
  logic rs_level;
  logic at_raw;
  logic usp_level;
  logic [NUM_LOGIC_OUT-1:0] delay_set;

  assign addr_phase = hsel & htrans[1] & hready;
  assign delay_set = {output_off_delay_c != 8'h00, output_off_delay_b != 8'h00, output_off_delay_a != 8'h00};

  // Terminal levels after polarity; reset terminals ignore inversion
  always_comb begin
    term_lvl = terminal_in;
    for (int i = 0; i < NUM_TERMINALS; i++) begin
      if (func_map[i*FUNC_CODE_W +: FUNC_CODE_W] != FUNC_RESET) begin
        term_lvl[i] = terminal_in[i] ^ polarity[i];
      end
    end
    rs_level = func_level(func_map, term_lvl, FUNC_RESET);
    at_raw = func_level(func_map, term_lvl, FUNC_CURRENT_SELECT);
    usp_level = func_level(func_map, term_lvl, FUNC_USP);
  end

  // Register bus
  always_comb begin
    next_wr_pending = addr_phase & hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_hrdata = hrdata;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        FUNC_MAP_OFFSET: next_hrdata = {7'h00, func_map};
        POLARITY_OFFSET: next_hrdata = {27'h000_0000, polarity};
        FREQ_CFG_OFFSET: next_hrdata = {16'h0000, analog_select_setting, freq_source_setting};
        OFF_DELAY_OFFSET: next_hrdata = {8'h00, output_off_delay_c, output_off_delay_b, output_off_delay_a};
        STATUS_OFFSET: next_hrdata = {21'h00_0000, logic_out, motor_drive, analog_source, rs_level, at_filt,
                                      phase == ST_RESET_HOLD, phase == ST_POWER_UP, trip};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
    next_func_map = func_map;
    next_polarity = polarity;
    next_freq_source_setting = freq_source_setting;
    next_analog_select_setting = analog_select_setting;
    next_output_off_delay_a = output_off_delay_a;
    next_output_off_delay_b = output_off_delay_b;
    next_output_off_delay_c = output_off_delay_c;
    if (wr_pending) begin
      unique case (wr_addr)
        FUNC_MAP_OFFSET: next_func_map = hwdata[24:0];
        POLARITY_OFFSET: next_polarity = hwdata[4:0];
        FREQ_CFG_OFFSET: begin
          next_freq_source_setting = hwdata[FREQ_SRC_LSB +: 8];
          next_analog_select_setting = hwdata[ANALOG_SEL_LSB +: 8];
        end
        OFF_DELAY_OFFSET: begin
          next_output_off_delay_a = hwdata[DELAY_A_LSB +: 8];
          next_output_off_delay_b = hwdata[DELAY_B_LSB +: 8];
          next_output_off_delay_c = hwdata[DELAY_C_LSB +: 8];
        end
        default: next_func_map = func_map;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      func_map <= FUNC_MAP_RESET;
      polarity <= POLARITY_RESET;
      freq_source_setting <= FREQ_SRC_RESET;
      analog_select_setting <= ANALOG_SEL_RESET;
      output_off_delay_a <= 8'h00;
      output_off_delay_b <= 8'h00;
      output_off_delay_c <= 8'h00;
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      func_map <= next_func_map;
      polarity <= next_polarity;
      freq_source_setting <= next_freq_source_setting;
      analog_select_setting <= next_analog_select_setting;
      output_off_delay_a <= next_output_off_delay_a;
      output_off_delay_b <= next_output_off_delay_b;
      output_off_delay_c <= next_output_off_delay_c;
      wr_pending <= next_wr_pending;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Reset sequencing, trip, analog routing and output gating
  always_comb begin
    next_at_cnt = at_cnt;
    next_at_filt = at_filt;
    if (at_raw == at_filt) begin
      next_at_cnt = 4'h0;
    end else if (at_cnt == AT_DEBOUNCE_CYCLES) begin
      next_at_filt = at_raw;
      next_at_cnt = 4'h0;
    end else begin
      next_at_cnt = at_cnt + 4'h1;
    end

    next_phase = phase;
    next_trip = trip;
    // Width counter saturates once the pulse is long enough
    if ((phase == ST_POWER_UP || rs_level) && rs_cnt != RESET_MIN) begin
      next_rs_cnt = rs_cnt + CNT_W'(1);
    end else if (phase != ST_POWER_UP && !rs_level) begin
      next_rs_cnt = '0;
    end else begin
      next_rs_cnt = rs_cnt;
    end
    unique case (phase)
      ST_POWER_UP: begin
        if (rs_cnt == RESET_MIN) begin
          next_phase = ST_NORMAL;
          next_trip = usp_level & run_cmd;
          next_rs_cnt = '0;
        end
      end
      ST_NORMAL: begin
        if (rs_level && rs_cnt == RESET_MIN) begin
          next_phase = ST_RESET_HOLD;
          next_trip = 1'b0;
        end
      end
      ST_RESET_HOLD: begin
        next_trip = 1'b0;
        if (!rs_level) begin
          next_phase = ST_NORMAL;
        end
      end
    endcase
    if (trip_event && phase == ST_NORMAL) begin
      next_trip = 1'b1;
    end

    if (rs_level && !rs_prev) begin
      next_off_cnt = OFF_DELAY;
    end else if (off_cnt != '0) begin
      next_off_cnt = off_cnt - CNT_W'(1);
    end else begin
      next_off_cnt = off_cnt;
    end

    next_analog_source = SRC_NONE;
    if (freq_source_setting == FREQ_SRC_ANALOG) begin
      unique case (analog_select_setting)
        ASEL_POT_OR_VOLTAGE: next_analog_source = at_filt ? SRC_KEYPAD_POT : SRC_VOLTAGE;
        ASEL_POT_OR_CURRENT: next_analog_source = at_filt ? SRC_KEYPAD_POT : SRC_CURRENT;
        ASEL_VOLTAGE_ONLY: next_analog_source = SRC_VOLTAGE;
        ASEL_CURRENT_ONLY: next_analog_source = SRC_CURRENT;
        default: next_analog_source = at_filt ? SRC_CURRENT : SRC_VOLTAGE;
      endcase
    end

    // Motor drops at once on reset and coasts; runs again only after trip clears and the reset input releases back to normal
    next_motor_drive = run_cmd & !trip & !rs_level & (phase == ST_NORMAL);
    // Next count, so a delayed output does not blank for one cycle on the reset rise
    for (int i = 0; i < NUM_LOGIC_OUT; i++) begin
      next_logic_out[i] = logic_out_req[i] & (!rs_level | (delay_set[i] & next_off_cnt != '0));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= ST_POWER_UP;
      rs_cnt <= '0;
      off_cnt <= '0;
      rs_prev <= 1'b0;
      trip <= 1'b0;
      at_filt <= 1'b0;
      at_cnt <= 4'h0;
      analog_source <= SRC_NONE;
      motor_drive <= 1'b0;
      logic_out <= '0;
      alarm_out <= 1'b0;
    end else begin
      phase <= next_phase;
      rs_cnt <= next_rs_cnt;
      off_cnt <= next_off_cnt;
      rs_prev <= rs_level;
      trip <= next_trip;
      at_filt <= next_at_filt;
      at_cnt <= next_at_cnt;
      analog_source <= next_analog_source;
      motor_drive <= next_motor_drive;
      logic_out <= next_logic_out;
      alarm_out <= next_trip;
    end
  end

endmodule : input_terminal

// *** verification/input_terminal_monitor.sv ***
// Port-level assertions for the input-terminal block
`timescale 1ns/100ps
module input_terminal_monitor
  import input_terminal_pkg::*;
#(
  parameter logic [CNT_W-1:0] RESET_MIN = CNT_W'(RESET_MIN_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic run_cmd,
  input wire logic trip_event,
  input wire logic [2:0] logic_out_req,
  input wire logic motor_drive,
  input wire logic [2:0] logic_out,
  input wire logic alarm_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] up_cnt;
  logic [31:0] next_up_cnt;
  // Cycles since the last power-on release, saturating
  always_comb begin
    next_up_cnt = (up_cnt == 32'hFFFF_FFFF) ? up_cnt : up_cnt + 32'h0000_0001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_cnt <= '0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end
  sequence trip_held_s;
    alarm_out ##1 alarm_out;
  endsequence
  ready_after_reset_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_hold_a: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  motor_needs_run_a: assert property (motor_drive |-> $past(run_cmd))
    else $error("motor driven without run");
  trip_stops_motor_a: assert property (trip_held_s |-> !motor_drive)
    else $error("motor driven while tripped");
  powerup_motor_off_a: assert property (up_cnt < RESET_MIN |-> !motor_drive)
    else $error("motor driven in power-up phase");
  powerup_no_alarm_a: assert property (up_cnt < RESET_MIN |-> !alarm_out)
    else $error("alarm during power-up phase");
  logic_needs_req_a: assert property ((logic_out & ~$past(logic_out_req)) == 3'b000)
    else $error("logic output on without request");
  alarm_cause_a: assert property ($rose(alarm_out) |->
    $past(trip_event) || $past(trip_event, 2) || up_cnt < RESET_MIN + 4)
    else $error("alarm without cause");
endmodule : input_terminal_monitor

bind input_terminal input_terminal_monitor #(.RESET_MIN(RESET_MIN)) mon_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .run_cmd(run_cmd), .trip_event(trip_event), .logic_out_req(logic_out_req),
  .motor_drive(motor_drive), .logic_out(logic_out), .alarm_out(alarm_out));

// *** verification/contact_model.sv ***
// Model of the contacts wired to the programmable input terminals
`timescale 1ns/100ps
module contact_model
  import input_terminal_pkg::*;
(
  input wire logic hclk,
  output logic [NUM_TERMINALS-1:0] terminal_in
);
  initial terminal_in = '0;
  // Normally open contact: closed drives the terminal high
  task set_level(input int idx, input logic v);
    terminal_in[idx] <= v;
    @(posedge hclk);
  endtask : set_level
  // Holds a contact closed for a number of cycles
  task pulse(input int idx, input int cycles);
    terminal_in[idx] <= 1'b1;
    repeat (cycles) @(posedge hclk);
    terminal_in[idx] <= 1'b0;
  endtask : pulse
endmodule : contact_model

// *** verification/input_terminal_tb.sv ***
// Self-checking testbench for the input-terminal block
`timescale 1ns/100ps
module input_terminal_tb;
  import input_terminal_pkg::*;
  localparam logic [CNT_W-1:0] RMIN = 28'd20;
  localparam logic [CNT_W-1:0] ODLY = 28'd30;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic run_cmd = 1'b0;
  logic trip_event = 1'b0;
  logic [2:0] logic_out_req = '0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [4:0] terminal_in;
  logic [1:0] analog_source;
  logic motor_drive;
  logic [2:0] logic_out;
  logic alarm_out;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic [31:0] rd;
  logic [7:0] sel [5] = '{8'h00, ASEL_POT_OR_VOLTAGE, ASEL_POT_OR_CURRENT, ASEL_VOLTAGE_ONLY, ASEL_CURRENT_ONLY};
  analog_source_e src [10] = '{SRC_VOLTAGE, SRC_CURRENT, SRC_VOLTAGE, SRC_KEYPAD_POT, SRC_CURRENT,
    SRC_KEYPAD_POT, SRC_VOLTAGE, SRC_VOLTAGE, SRC_CURRENT, SRC_CURRENT};
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  contact_model model_u (.hclk(hclk), .terminal_in(terminal_in));
  input_terminal #(.RESET_MIN(RMIN), .OFF_DELAY(ODLY)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .terminal_in(terminal_in), .run_cmd(run_cmd),
    .trip_event(trip_event), .logic_out_req(logic_out_req), .analog_source(analog_source),
    .motor_drive(motor_drive), .logic_out(logic_out), .alarm_out(alarm_out));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // One single AHB-Lite transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk
  initial begin
    repeat (3000) @(posedge hclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(FREQ_CFG_OFFSET, 32'h0000_0001);
    rd_chk(FUNC_MAP_OFFSET, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    model_u.set_level(1, 1'b1);
    repeat (12) @(posedge hclk);
    check({30'h0, analog_source}, {30'h0, SRC_VOLTAGE});
    bus(1'b1, FREQ_CFG_OFFSET, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    check({30'h0, analog_source}, {30'h0, SRC_NONE});
    bus(1'b1, FUNC_MAP_OFFSET, {7'h0, 5'h0, FUNC_RESET, 5'h0, FUNC_CURRENT_SELECT, 5'h0});
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, FREQ_CFG_OFFSET, {16'h0, sel[i/2], FREQ_SRC_ANALOG});
      model_u.set_level(1, i[0]);
      repeat (12) @(posedge hclk);
      check({30'h0, analog_source}, {30'h0, src[i]});
    end
    run_cmd <= 1'b1;
    logic_out_req <= 3'b111;
    bus(1'b1, POLARITY_OFFSET, 32'h0000_0008);
    bus(1'b1, OFF_DELAY_OFFSET, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    rd_chk(POLARITY_OFFSET, 32'h0000_0008);
    check({31'h0, motor_drive}, 32'h0000_0001);
    trip_event <= 1'b1;
    @(posedge hclk);
    trip_event <= 1'b0;
    repeat (3) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0001);
    model_u.pulse(3, 10);
    repeat (5) @(posedge hclk);
    check({31'h0, alarm_out}, 32'h0000_0001);
    fork
      model_u.pulse(3, 40);
    join_none
    n = 0;
    for (int i = 1; i <= ODLY + 6; i++) begin
      @(posedge hclk);
      if (alarm_out === 1'b1) n = i;
      if (i == 2) check({28'h0, motor_drive, logic_out}, 32'h0000_0001);
      if (i == 4) check({28'h0, motor_drive, logic_out}, 32'h0000_0001);
      if (i == ODLY + 1) check({28'h0, motor_drive, logic_out}, 32'h0000_0001);
      if (i == ODLY + 2) check({28'h0, motor_drive, logic_out}, 32'h0000_0000);
      if (i == ODLY + 6) check({28'h0, motor_drive, logic_out}, 32'h0000_0000);
    end
    check({31'h0, n >= 18 && n <= 50}, 32'h0000_0001);
    repeat (8) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0002);
    fork
      model_u.pulse(3, 25);
    join_none
    repeat (4) @(posedge hclk);
    check({31'h0, motor_drive}, 32'h0000_0000);
    repeat (30) @(posedge hclk);
    trip_event <= 1'b1;
    @(posedge hclk);
    trip_event <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0000);
    repeat (RMIN + 6) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0002);
    // Power up again with run held and the start guard mapped: it must trip, and a reset pulse restarts
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b1, FUNC_MAP_OFFSET, {7'h0, 5'h0, FUNC_RESET, 5'h0, 5'h0, FUNC_USP});
    model_u.set_level(0, 1'b1);
    repeat (RMIN + 6) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0001);
    fork
      model_u.pulse(3, 25);
    join_none
    repeat (32) @(posedge hclk);
    check({30'h0, motor_drive, alarm_out}, 32'h0000_0002);
    wrap_up();
  end
endmodule : input_terminal_tb
